/* File: core/erw_pkg.sv */
package erw_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_PORT_FMT   = 8'h00;
	localparam logic [7:0] REG_TBL_COMMIT = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;
	localparam logic [7:0] REG_STAGE_BASE = 8'h40;
	localparam int         FMT_FIELD_W    = 2;
	localparam int         CNT_W          = 16;

	// ----------------------------------------------------------------
	// Port header formats and field source selections
	// ----------------------------------------------------------------
	localparam logic [1:0] FMT_NORMAL  = 2'h0;
	localparam logic [1:0] FMT_KEEP    = 2'h1;
	localparam logic [1:0] FMT_ENC_MAC = 2'h2;
	localparam logic [1:0] FMT_ENC_TBL = 2'h3;
	localparam logic [1:0] SRC_CLS     = 2'h0;
	localparam logic [1:0] SRC_FIXED   = 2'h1;
	localparam logic [1:0] SRC_MIX     = 2'h2;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam logic [15:0] MPLS_ETYPE   = 16'h8847;
	localparam int          MAC_BYTES    = 6;
	localparam int          HDR_BYTES    = 12;
	localparam int          WORD_BYTES   = 4;
	localparam int          ETYPE_BYTES  = 2;
	localparam int          MAX_TAGS     = 2;
	localparam int          MAX_LABELS   = 3;
	localparam int          SMAC_CLR_BIT = 40;
	localparam int          ENCAP_MAX    = 2 * MAC_BYTES + MAX_TAGS * WORD_BYTES + ETYPE_BYTES
		+ (MAX_LABELS + 1) * WORD_BYTES;

	typedef struct packed {
		logic [19:0] value;
		logic [2:0]  tc;
		logic        sbit;
		logic [7:0]  ttl;
		logic        label_value_source;
		logic [1:0]  traffic_class_source;
		logic [1:0]  bottom_of_stack_source;
		logic [1:0]  ttl_sel;
	} erw_lbl_s;

	typedef struct packed {
		logic [15:0] tpid;
		logic [11:0] vid;
		logic [2:0]  pcp;
		logic        dei;
		logic [2:0]  pcp_sel;
		logic [2:0]  dei_sel;
	} erw_tag_s;

	typedef struct packed {
		logic [47:0]            ll_dmac;
		logic [47:0]            ll_smac;
		logic [1:0]             tag_cnt;
		erw_tag_s [1:0]         tags;
		logic [1:0]             lbl_cnt;
		erw_lbl_s [2:0]         lbls;
		logic                   control_word_insert_on;
		logic                   inner_sel;
		logic                   rsv_ena;
		logic                   rsv_after;
	} erw_entry_s;

	localparam int ENTRY_W     = $bits(erw_entry_s);
	localparam int ENTRY_WORDS = (ENTRY_W + 31) / 32;

	typedef enum logic [2:0] {
		ERW_IDLE   = 3'b001,
		ERW_PREFIX = 3'b010,
		ERW_BODY   = 3'b100
	} erw_state_e;

endpackage

/* File: core/erw_lbl_if.sv */
`timescale 1ns/1ps
interface erw_lbl_if;
	import erw_pkg::*;
	erw_lbl_s    cfg;
	logic [31:0] es0_word;
	logic        use_es0;
	logic        oam;
	logic [2:0]  cls_tc;
	logic        cls_sbit;
	logic [7:0]  cls_ttl;
	logic [2:0]  map_tc;
	logic [19:0] map_val;
	logic [31:0] label;

	modport ctl (output cfg, es0_word, use_es0, oam, cls_tc, cls_sbit, cls_ttl, map_tc, map_val, input label);
	modport lab (input cfg, es0_word, use_es0, oam, cls_tc, cls_sbit, cls_ttl, map_tc, map_val, output label);
endinterface

/* File: core/erw_label_remark.sv */
`timescale 1ns/1ps
module erw_label_remark
	import erw_pkg::*;
(
	erw_lbl_if.lab lb
);
	logic [19:0] val;
	logic [2:0]  tc;
	logic        sbit;
	logic [7:0]  ttl;

	// ----------------------------------------------------------------
	// Field selection for one pushed label.
	// ----------------------------------------------------------------
	always_comb
	begin
		val  = lb.cfg.label_value_source ? lb.map_val : lb.cfg.value;
		case (lb.cfg.traffic_class_source)
			SRC_CLS:   tc = lb.cls_tc;
			SRC_MIX:   tc = lb.map_tc;
			default:   tc = lb.cfg.tc;
		endcase
		case (lb.cfg.bottom_of_stack_source)
			SRC_CLS:   sbit = lb.cls_sbit;
			SRC_MIX:   sbit = lb.oam ? lb.cls_sbit : lb.cfg.sbit;
			default:   sbit = lb.cfg.sbit;
		endcase
		case (lb.cfg.ttl_sel)
			SRC_CLS:   ttl = lb.cls_ttl;
			SRC_MIX:   ttl = lb.oam ? lb.cls_ttl : lb.cfg.ttl;
			default:   ttl = lb.cfg.ttl;
		endcase
	end

	// The innermost label may be taken whole from the lookup action.
	assign lb.label = lb.use_es0 ? lb.es0_word : {val, tc, sbit, ttl};

endmodule

/* File: core/erw_mac_swap.sv */
`timescale 1ns/1ps
module erw_mac_swap
	import erw_pkg::*;
(
	input  wire logic [47:0] dmac,
	input  wire logic [47:0] smac,
	output logic      [95:0] hdr
);
	logic [47:0] new_smac;

	// The old destination becomes the source with its group bit cleared.
	always_comb
	begin
		new_smac               = dmac;
		new_smac[SMAC_CLR_BIT] = 1'b0;
	end

	assign hdr = {smac, new_smac};

endmodule

/* File: core/erw_rewriter.sv */
// What this block does
// - Encapsulation index zero disables label pushing.
// - Up to three labels, four selections each.
// - Link tags remarked like ordinary Ethernet tags.
// - Innermost label optionally taken from lookup action.
// - Lookup action can suppress control word.
// - Label value from mapping or entry.
// - OAM frames get reserved label, not control word.
// - Bottom-of-stack source zero takes classified bit.
// - Hop-limit source zero takes classified TTL.
// - Traffic class remarked by generic mapping.
// - Traffic class source zero takes classified value.
// - Header insertion puts header on every non-bypassed frame outside format zero.
// - Format zero normal, one keeps header unmodified.
// - Format two prepends frame MACs and vendor tag.
// - Format three prepends table entry encapsulation.
// - CPU ports always use keep-header format.
// - Keep format frames are not standard Ethernet.
// - Encapsulating formats include header in checksum.
// - Bypass forwards unchanged except checksum refresh.
// - Refresh bit forces checksum recompute.
// - MAC swap, clear bit 40, force checksum.
// - Bottom-of-stack source: classified, fixed, mixed.
// - Hop-limit source: classified, fixed, mixed.
`timescale 1ns/1ps
module erw_rewriter
	import erw_pkg::*;
#(
	parameter int          N_PORTS        = 13,
	parameter int          CPU_PORT_FIRST = 11,
	parameter int          ENCAP_DEPTH    = 128,
	parameter int          IFH_BYTES      = 16,
	parameter logic [15:0] VENDOR_ETYPE   = 16'hAAAA, // Arbitrary value.
	parameter logic [15:0] VENDOR_EPID    = 16'h0001, // Arbitrary value.
	parameter logic [19:0] RSV_LABEL      = 20'h0_000F,
	parameter logic [7:0]  RSV_TTL        = 8'h01,
	localparam int         PORT_W         = $clog2(N_PORTS),
	localparam int         IDX_W          = $clog2(ENCAP_DEPTH),
	localparam int         IFH_W          = IFH_BYTES * 8
)
(
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    in_valid,
	output logic                         in_ready,
	input  wire logic [7:0]              in_data,
	input  wire logic                    in_sop,
	input  wire logic                    in_eop,
	input  wire logic [PORT_W-1:0]       sb_port,
	input  wire logic [IFH_W-1:0]        sb_ifh,
	input  wire logic                    sb_bypass,
	input  wire logic                    sb_update_fcs,
	input  wire logic                    sb_swap,
	input  wire logic [IDX_W-1:0]        sb_encap_index,
	input  wire logic                    sb_cw_dis,
	input  wire logic [31:0]             sb_inner_label,
	input  wire logic                    sb_oam,
	input  wire logic [2:0]              sb_cls_tc,
	input  wire logic                    sb_cls_sbit,
	input  wire logic [7:0]              sb_cls_ttl,
	input  wire logic [2:0][2:0]         sb_map_tc,
	input  wire logic [2:0][19:0]        sb_map_lbl,
	input  wire logic [2:0]              sb_cls_pcp,
	input  wire logic                    sb_cls_dei,
	input  wire logic                    sb_dp_dei,
	input  wire logic [3:0][2:0]         sb_map_pcp,
	input  wire logic [3:0]              sb_map_dei,
	input  wire logic [3:0]              sb_map_hit,
	input  wire logic [47:0]             sb_dmac,
	input  wire logic [47:0]             sb_smac,
	output logic                         out_valid,
	input  wire logic                    out_ready,
	output logic [7:0]                   out_data,
	output logic                         out_sop,
	output logic                         out_eop,
	output logic                         out_fcs_update
);
	localparam int PRE_MAX = ENCAP_MAX + IFH_BYTES;
	localparam int PRE_W   = PRE_MAX * 8;
	localparam int LEN_W   = $clog2(PRE_MAX + 1);

	generate
		if (N_PORTS * FMT_FIELD_W > 32 || CPU_PORT_FIRST >= N_PORTS || ENCAP_DEPTH < 2 || IFH_BYTES < 1)
		begin : g_bad
			$error("erw_rewriter: unsupported parameter values");
		end
	endgenerate

	erw_state_e                 state_reg;
	logic [N_PORTS*2-1:0]       port_fmt_reg;
	logic [ENTRY_WORDS*32-1:0]  stage_reg;
	erw_entry_s                 table_reg [ENCAP_DEPTH];
	logic [CNT_W-1:0]           frames_reg;
	logic [PRE_W-1:0]           pre_reg;
	logic [LEN_W-1:0]           pre_len_reg;
	logic [LEN_W-1:0]           pre_cnt_reg;
	logic                       first_reg;
	logic                       swap_reg;
	logic                       fcs_reg;
	logic [47:0]                dmac_reg;
	logic [47:0]                smac_reg;
	logic [3:0]                 body_cnt_reg;
	logic [7:0]                 out_data_reg;
	logic                       out_valid_reg;
	logic                       out_sop_reg;
	logic                       out_eop_reg;
	logic [31:0]                prdata_reg;
	logic                       pslverr_reg;

	erw_entry_s                 ent;
	logic [1:0]                 fmt_eff;
	logic                       start;
	logic                       load;
	logic                       emit_pre;
	logic                       emit_body;
	logic [PRE_W-1:0]           pre_next;
	logic [LEN_W-1:0]           len_next;
	logic                       swap_next;
	logic                       fcs_next;
	logic [95:0]                swap_hdr;
	logic [31:0]                lbl_word [MAX_LABELS];
	logic [31:0]                tag_word [MAX_TAGS];
	logic [7:0]                 body_byte;

	// ----------------------------------------------------------------
	// Frame start decisions
	// ----------------------------------------------------------------
	assign ent     = table_reg[sb_encap_index];
	assign start   = (state_reg == ERW_IDLE) && in_valid && in_sop;
	assign load    = !out_valid_reg || out_ready;
	assign fmt_eff = (32'(sb_port) >= CPU_PORT_FIRST) ? FMT_KEEP
		: port_fmt_reg[FMT_FIELD_W*sb_port +: FMT_FIELD_W];

	function automatic logic [2:0] remark3(input logic [2:0] sel, input logic [2:0] cls, input logic [2:0] fixed,
		input logic [2:0] dpv, input logic [3:0][2:0] map, input logic [3:0] hit);
		case (sel)
			3'h0:    remark3 = cls;
			3'h2:    remark3 = dpv;
			3'h4:    remark3 = hit[0] ? map[0] : fixed;
			3'h5:    remark3 = hit[1] ? map[1] : map[0];
			3'h6:    remark3 = hit[2] ? map[2] : fixed;
			3'h7:    remark3 = hit[3] ? map[3] : map[2];
			default: remark3 = fixed;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < MAX_TAGS; gi++)
		begin : g_tag
			logic [3:0][2:0] dei_map;
			logic [2:0]      pcp;
			logic [2:0]      dei;
			always_comb
			begin
				dei_map = {{2'h0, sb_map_dei[3]}, {2'h0, sb_map_dei[2]}, {2'h0, sb_map_dei[1]}, {2'h0, sb_map_dei[0]}};
				pcp = remark3(ent.tags[gi].pcp_sel, sb_cls_pcp, ent.tags[gi].pcp, ent.tags[gi].pcp,
					sb_map_pcp, sb_map_hit);
				dei = remark3(ent.tags[gi].dei_sel, {2'h0, sb_cls_dei}, {2'h0, ent.tags[gi].dei},
					{2'h0, sb_dp_dei}, dei_map, sb_map_hit);
			end
			assign tag_word[gi] = {ent.tags[gi].tpid, pcp, dei[0], ent.tags[gi].vid};
		end
		for (gi = 0; gi < MAX_LABELS; gi++)
		begin : g_lbl
			erw_lbl_if lif ();
			assign lif.cfg      = ent.lbls[gi];
			assign lif.es0_word = sb_inner_label;
			assign lif.use_es0  = ent.inner_sel && (gi == 32'(ent.lbl_cnt) - 1);
			assign lif.oam      = sb_oam;
			assign lif.cls_tc   = sb_cls_tc;
			assign lif.cls_sbit = sb_cls_sbit;
			assign lif.cls_ttl  = sb_cls_ttl;
			assign lif.map_tc   = sb_map_tc[gi];
			assign lif.map_val  = sb_map_lbl[gi];
			erw_label_remark u_lbl (
				.lb (lif.lab)
			);
			assign lbl_word[gi] = lif.label;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Prefix assembly, most significant byte leaves first
	// ----------------------------------------------------------------
	always_comb
	begin
		logic rsv_ins;
		logic cw_ins;
		rsv_ins   = ent.rsv_ena && sb_oam;
		cw_ins    = ent.control_word_insert_on && !sb_cw_dis;
		pre_next  = '0;
		len_next  = '0;
		swap_next = 1'b0;
		fcs_next  = sb_update_fcs;
		if (!sb_bypass)
		begin
			swap_next = sb_swap && (fmt_eff != FMT_KEEP);
			if (swap_next)
				fcs_next = 1'b1;
			if (fmt_eff == FMT_ENC_MAC)
			begin
				pre_next = {pre_next[PRE_W-129:0], sb_dmac, sb_smac, VENDOR_ETYPE, VENDOR_EPID};
				len_next = LEN_W'(HDR_BYTES + 2 * ETYPE_BYTES);
			end
			else if ((fmt_eff == FMT_ENC_TBL || fmt_eff == FMT_NORMAL) && sb_encap_index != '0)
			begin
				pre_next = {pre_next[PRE_W-97:0], ent.ll_dmac, ent.ll_smac};
				len_next = LEN_W'(HDR_BYTES);
				for (int t = 0; t < MAX_TAGS; t++)
					if (t < 32'(ent.tag_cnt))
					begin
						pre_next = {pre_next[PRE_W-33:0], tag_word[t]};
						len_next = len_next + LEN_W'(WORD_BYTES);
					end
				if (fmt_eff == FMT_ENC_TBL)
				begin
					pre_next = {pre_next[PRE_W-33:0], VENDOR_ETYPE, VENDOR_EPID};
					len_next = len_next + LEN_W'(2 * ETYPE_BYTES);
				end
				else
				begin
					pre_next = {pre_next[PRE_W-17:0], MPLS_ETYPE};
					len_next = len_next + LEN_W'(ETYPE_BYTES);
					for (int l = 0; l < MAX_LABELS; l++)
						if (l < 32'(ent.lbl_cnt))
						begin
							if (rsv_ins && !ent.rsv_after && l == 32'(ent.lbl_cnt) - 1)
							begin
								pre_next = {pre_next[PRE_W-33:0], RSV_LABEL, 3'h0, 1'b0, RSV_TTL};
								len_next = len_next + LEN_W'(WORD_BYTES);
							end
							pre_next = {pre_next[PRE_W-33:0], lbl_word[l]};
							len_next = len_next + LEN_W'(WORD_BYTES);
						end
					if (rsv_ins && ent.rsv_after)
					begin
						pre_next = {pre_next[PRE_W-33:0], RSV_LABEL, 3'h0, 1'b1, RSV_TTL};
						len_next = len_next + LEN_W'(WORD_BYTES);
					end
					else if (cw_ins && !rsv_ins)
					begin
						pre_next = {pre_next[PRE_W-33:0], 32'h0000_0000};
						len_next = len_next + LEN_W'(WORD_BYTES);
					end
					fcs_next = 1'b1;
				end
			end
			if (fmt_eff != FMT_NORMAL)
			begin
				pre_next = {pre_next[PRE_W-IFH_W-1:0], sb_ifh};
				len_next = len_next + LEN_W'(IFH_BYTES);
			end
			if (fmt_eff == FMT_ENC_MAC || fmt_eff == FMT_ENC_TBL)
				fcs_next = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencing
	// ----------------------------------------------------------------
	assign emit_pre  = (state_reg == ERW_PREFIX) && load;
	assign in_ready  = (state_reg == ERW_BODY) && load;
	assign emit_body = in_ready && in_valid;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			state_reg <= ERW_IDLE;
		else
			case (state_reg)
				ERW_IDLE:   if (start) state_reg <= (len_next != '0) ? ERW_PREFIX : ERW_BODY;
				ERW_PREFIX: if (emit_pre && pre_cnt_reg == LEN_W'(1)) state_reg <= ERW_BODY;
				ERW_BODY:   if (emit_body && in_eop) state_reg <= ERW_IDLE;
				default:    state_reg <= ERW_IDLE;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			pre_reg     <= '0;
			pre_len_reg <= '0;
			pre_cnt_reg <= '0;
			swap_reg    <= 1'b0;
			fcs_reg     <= 1'b0;
			dmac_reg    <= '0;
			smac_reg    <= '0;
		end
		else if (start)
		begin
			pre_reg     <= pre_next;
			pre_len_reg <= len_next;
			pre_cnt_reg <= len_next;
			swap_reg    <= swap_next;
			fcs_reg     <= fcs_next;
			dmac_reg    <= sb_dmac;
			smac_reg    <= sb_smac;
		end
		else if (emit_pre)
			pre_cnt_reg <= pre_cnt_reg - LEN_W'(1);
	end

	erw_mac_swap u_swap (
		.dmac (dmac_reg),
		.smac (smac_reg),
		.hdr  (swap_hdr)
	);

	assign body_byte = (swap_reg && body_cnt_reg < 4'(HDR_BYTES))
		? swap_hdr[95 - 8 * body_cnt_reg -: 8] : in_data;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
			out_sop_reg   <= 1'b0;
			out_eop_reg   <= 1'b0;
			first_reg     <= 1'b0;
			body_cnt_reg  <= '0;
		end
		else
		begin
			if (start)
			begin
				first_reg    <= 1'b1;
				body_cnt_reg <= '0;
			end
			if (emit_pre)
			begin
				out_data_reg <= pre_reg[8 * (pre_cnt_reg - LEN_W'(1)) +: 8];
				out_sop_reg  <= first_reg;
				out_eop_reg  <= 1'b0;
				first_reg    <= 1'b0;
			end
			else if (emit_body)
			begin
				out_data_reg <= body_byte;
				out_sop_reg  <= first_reg;
				out_eop_reg  <= in_eop;
				first_reg    <= 1'b0;
				if (body_cnt_reg < 4'(HDR_BYTES))
					body_cnt_reg <= body_cnt_reg + 4'h1;
			end
			if (emit_pre || emit_body)
				out_valid_reg <= 1'b1;
			else if (out_ready)
				out_valid_reg <= 1'b0;
		end
	end

	assign out_valid      = out_valid_reg;
	assign out_data       = out_data_reg;
	assign out_sop        = out_sop_reg;
	assign out_eop        = out_eop_reg;
	assign out_fcs_update = fcs_reg;

	// ----------------------------------------------------------------
	// APB register slave
	// ----------------------------------------------------------------
	logic apb_wr;
	logic stage_hit;
	logic [7:0] stage_idx;
	assign apb_wr    = psel && penable && pwrite;
	assign stage_idx = (paddr - REG_STAGE_BASE) >> 2;
	assign stage_hit = paddr >= REG_STAGE_BASE && 32'(stage_idx) < ENTRY_WORDS && paddr[1:0] == 2'h0;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			port_fmt_reg <= '0;
			stage_reg    <= '0;
			for (int e = 0; e < ENCAP_DEPTH; e++)
				table_reg[e] <= '0;
		end
		else if (apb_wr)
		begin
			if (paddr == REG_PORT_FMT)
				port_fmt_reg <= pwdata[N_PORTS*2-1:0];
			else if (paddr == REG_TBL_COMMIT)
				table_reg[pwdata[IDX_W-1:0]] <= stage_reg[ENTRY_W-1:0];
			else if (stage_hit)
				stage_reg[32 * stage_idx +: 32] <= pwdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			frames_reg <= '0;
		else if (emit_body && in_eop)
			frames_reg <= frames_reg + CNT_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
			if (paddr == REG_PORT_FMT)
				prdata_reg <= 32'(port_fmt_reg);
			else if (paddr == REG_STATUS)
				prdata_reg <= {13'h0000, state_reg, frames_reg};
			else if (stage_hit)
				prdata_reg <= stage_reg[32 * stage_idx +: 32];
			else if (paddr != REG_TBL_COMMIT)
				pslverr_reg <= 1'b1;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = (psel && penable && !pwrite) ? prdata_reg : 32'h0000_0000;
	assign pslverr = psel && penable && pslverr_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	localparam int ENC_MAC_LEN = HDR_BYTES + 2 * ETYPE_BYTES + IFH_BYTES;

	cpu_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
		start && !sb_bypass && 32'(sb_port) >= CPU_PORT_FIRST |=> pre_len_reg == LEN_W'(IFH_BYTES) && !swap_reg)
		else $error("CPU port frame not in keep format");
	no_push_a: assert property (@(posedge clk) disable iff (!reset_n)
		start && !sb_bypass && fmt_eff == FMT_NORMAL && sb_encap_index == '0 |=> state_reg == ERW_BODY)
		else $error("prefix emitted with zero encapsulation index");
	bypass_fwd_a: assert property (@(posedge clk) disable iff (!reset_n)
		start && sb_bypass |=> state_reg == ERW_BODY && !swap_reg && fcs_reg == $past(sb_update_fcs))
		else $error("bypassed frame was modified");
	fcs_refresh_a: assert property (@(posedge clk) disable iff (!reset_n)
		start && sb_update_fcs |=> fcs_reg)
		else $error("checksum refresh request lost");
	swap_fcs_a: assert property (@(posedge clk) disable iff (!reset_n)
		start && sb_swap && !sb_bypass && fmt_eff != FMT_KEEP |=> swap_reg && fcs_reg)
		else $error("MAC swap without checksum update");
	swap_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
		emit_body && swap_reg && body_cnt_reg == 4'(MAC_BYTES) |=> out_data_reg[0] == 1'b0)
		else $error("new source address keeps group bit");
	enc_mac_len_a: assert property (@(posedge clk) disable iff (!reset_n)
		start && !sb_bypass && fmt_eff == FMT_ENC_MAC |=> pre_len_reg == LEN_W'(ENC_MAC_LEN) ##1 state_reg == ERW_PREFIX)
		else $error("MAC encapsulation length wrong");
	encap_fcs_a: assert property (@(posedge clk) disable iff (!reset_n)
		start && !sb_bypass && fmt_eff[1] |=> fcs_reg)
		else $error("encapsulated header outside checksum");
	ifh_present_a: assert property (@(posedge clk) disable iff (!reset_n)
		start && !sb_bypass && fmt_eff != FMT_NORMAL |=> state_reg == ERW_PREFIX && pre_len_reg >= LEN_W'(IFH_BYTES))
		else $error("internal header missing");

	bypass_c: cover property (@(posedge clk) disable iff (!reset_n) start && sb_bypass && sb_update_fcs);
	push_c:   cover property (@(posedge clk) disable iff (!reset_n)
		start && !sb_bypass && fmt_eff == FMT_NORMAL && sb_encap_index != '0 && ent.lbl_cnt == 2'h3);
	swap_c:   cover property (@(posedge clk) disable iff (!reset_n) emit_body && swap_reg && in_eop);

endmodule

/* File: verif/erw_sink.sv */
`timescale 1ns/1ps
module erw_sink (
	input  wire logic       clk,
	input  wire logic       valid,
	input  wire logic [7:0] data,
	input  wire logic       eop,
	input  wire logic       fcs,
	output logic            ready
);
	logic [7:0] got[$];
	int         frames;
	logic       fcs_seen;
	initial ready = 1'b0;
	// Port path that stalls at random.
	always @(posedge clk)
	begin
		if (valid && ready)
		begin
			got.push_back(data);
			if (eop)
			begin
				frames++;
				fcs_seen = fcs;
			end
		end
		ready <= ($urandom % 4) != 0;
	end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import erw_pkg::*;
	localparam logic [15:0] VET = 16'h5A5A; // Arbitrary value.
	localparam logic [15:0] VEP = 16'h0101; // Arbitrary value.
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, in_valid, in_ready, in_sop, in_eop, er;
	logic out_valid, out_ready, out_sop, out_eop, out_fcs_update, byp, upd, swp;
	logic [7:0]   paddr, in_data, out_data, fr[$], ex[$];
	logic [31:0]  pwdata, prdata, rd, internal_frame_header;
	logic [3:0]   port;
	logic [47:0]  dm, sm, ld, ls;
	logic [19:0]  lv;
	logic [6:0]   eidx;
	logic [127:0] r;
	int           num_errors, n_tests;
	erw_rewriter #(.IFH_BYTES(4), .VENDOR_ETYPE(VET), .VENDOR_EPID(VEP)) uut (.clk, .reset_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_data, .in_sop, .in_eop,
		.sb_port(port), .sb_ifh(internal_frame_header), .sb_bypass(byp), .sb_update_fcs(upd), .sb_swap(swp), .sb_encap_index(eidx),
		.sb_cw_dis(r[0]), .sb_inner_label(r[32:1]), .sb_oam(r[33]), .sb_cls_tc(r[36:34]), .sb_cls_sbit(r[37]),
		.sb_cls_ttl(r[45:38]), .sb_map_tc(r[54:46]), .sb_map_lbl(r[114:55]), .sb_cls_pcp(r[117:115]),
		.sb_cls_dei(r[118]), .sb_dp_dei(r[119]), .sb_map_pcp(r[11:0]), .sb_map_dei(r[15:12]),
		.sb_map_hit(r[19:16]), .sb_dmac(dm), .sb_smac(sm), .out_valid, .out_ready, .out_data, .out_sop,
		.out_eop, .out_fcs_update);
	erw_sink sink (.clk, .valid(out_valid), .data(out_data), .eop(out_eop), .fcs(out_fcs_update), .ready(out_ready));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Puts n bytes of v in front of the expected frame, most significant first.
	function automatic void put(input logic [127:0] v, input int n);
		for (int i = 0; i < n; i++)
			ex.push_front(v[8*i +: 8]);
	endfunction
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic load_entry(input logic [6:0] x);
		erw_entry_s                en;
		logic [ENTRY_WORDS*32-1:0] ew;
		ld = 48'({$urandom, $urandom});
		ls = 48'({$urandom, $urandom});
		lv = 20'($urandom);
		en = '0;
		en.ll_dmac = ld;
		en.ll_smac = ls;
		en.lbl_cnt = 2'h1;
		en.lbls[0].value = lv;
		en.control_word_insert_on = 1'b1;
		ew = '0;
		ew[ENTRY_W-1:0] = en;
		for (int i = 0; i < ENTRY_WORDS; i++)
			apb(1'b1, REG_STAGE_BASE + 8'(4 * i), ew[32*i +: 32]);
		apb(1'b0, REG_STAGE_BASE, 32'h0000_0000);
		chk("staging word", ew[31:0], rd);
		apb(1'b1, REG_TBL_COMMIT, 32'(x));
	endtask
	task automatic run(input logic [1:0] f, input logic [3:0] p, input logic b, input logic u, input logic s,
		input logic [6:0] x = 7'h00);
		logic [47:0]  d, m;
		logic [95:0]  hd;
		logic [127:0] rr;
		logic [31:0]  h;
		logic         ef;
		int           c0;
		d = 48'({$urandom, $urandom});
		m = 48'({$urandom, $urandom});
		rr = {$urandom, $urandom, $urandom, $urandom};
		h = $urandom;
		hd = {d, m};
		fr = {};
		for (int i = 0; i < 12; i++)
			fr.push_back(hd[95-8*i -: 8]);
		repeat (2 + $urandom % 8) fr.push_back(8'($urandom));
		apb(1'b1, REG_PORT_FMT, {30'h0, f});
		apb(1'b0, REG_PORT_FMT, 32'h0);
		chk("port format", {30'h0, f}, rd);
		ex = fr;
		hd = {m, d & ~(48'h1 << SMAC_CLR_BIT)};
		if (p >= 11)
			f = FMT_KEEP;
		ef = u || (!b && ((s || x != 7'h00) && f == FMT_NORMAL || f >= FMT_ENC_MAC));
		if (!b && s && f != FMT_KEEP)
			for (int i = 0; i < 12; i++)
				ex[i] = hd[95-8*i -: 8];
		if (!b && f != FMT_NORMAL)
			put(h, 4);
		if (!b && f == FMT_ENC_MAC)
			put({d, m, VET, VEP}, 16);
		if (!b && x != 7'h00 && f == FMT_ENC_TBL)
			put({ld, ls, VET, VEP}, 16);
		if (!b && x != 7'h00 && f == FMT_NORMAL)
		begin
			if (!rr[0])
				put(32'h0000_0000, 4);
			put({lv, rr[36:34], rr[37], rr[45:38]}, 4);
			put({ld, ls, MPLS_ETYPE}, 14);
		end
		// Sideband held steady for the whole frame.
		dm <= d;
		sm <= m;
		port <= p;
		byp <= b;
		upd <= u;
		swp <= s;
		eidx <= x;
		r <= rr;
		internal_frame_header <= h;
		c0 = sink.frames; sink.got = {};
		foreach (fr[i])
		begin
			in_data <= fr[i];
			in_sop <= i == 0;
			in_eop <= i == fr.size() - 1;
			in_valid <= 1'b1;
			do @(posedge clk); while (in_ready !== 1'b1);
		end
		in_valid <= 1'b0;
		for (int t = 0; t < 200 && sink.frames == c0; t++) @(posedge clk);
		chk("length", ex.size(), sink.got.size());
		foreach (ex[i])
			chk("byte", ex[i], sink.got[i]);
		chk("fcs", ef, sink.fcs_seen);
		$display("test fmt %0d port %0d done", f, p);
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, in_valid, in_data, in_sop, in_eop} = '0;
		{port, byp, upd, swp, dm, sm, r, internal_frame_header, eidx} = '0;
		void'($urandom(48357));
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, REG_PORT_FMT, 32'h0);
		chk("format reset", 32'h0, rd);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped error", 1, er);
		chk("unmapped data", 0, rd);
		run(FMT_NORMAL, 0, 0, 0, 0);
		run(FMT_KEEP, 0, 0, 0, 0);
		run(FMT_ENC_MAC, 0, 0, 0, 0);
		run(FMT_ENC_TBL, 0, 0, 0, 0);
		run(FMT_NORMAL, 11, 0, 0, 0);
		run(FMT_NORMAL, 11, 1, 1, 0);
		run(FMT_ENC_MAC, 12, 1, 0, 0);
		run(FMT_NORMAL, 0, 0, 0, 1);
		run(FMT_KEEP, 0, 0, 1, 0);
		load_entry(7'h01);
		run(FMT_ENC_TBL, 0, 0, 0, 0, 7'h01);
		repeat (3) run(FMT_NORMAL, 0, 0, 0, 0, 7'h01);
		give_verdict();
	end
	initial
	begin
		#60000;
		num_errors++;
		give_verdict();
	end
endmodule
